//--- rtl/osc_clock_ctrl.sv
// oscillator enable, clock routing, master clock rate selection and the
// soft-error-check controller with its register port and interrupt
// assumes fabric inputs and the cell array run on clk; clk is the raw oscillator
`default_nettype none
// Function
// - oscillator runs only when configuration enable and user enable are both high.
// - oscillator output offered to the clock tree and as pll reference.
// - oscillator output divided by a programmable divider for slower clocks.
// - master clock starts at 2.08 MHz after power-up.
// - master clock switches once the clock selection bits are received.
// - without a selection the master clock stays at 2.08 MHz.
// - master clock rates form a fixed table from 2.08 to 133 MHz.
// - check option set means a crc check runs after configuration completes.
// - fabric start input launches a check during user operation.
// - check clock comes from its own divider fed by the undivided oscillator.
// - check circuit can be switched off entirely to save power.
module osc_clock_ctrl
    import osc_pkg::*;
#(
    parameter int WORDS = CELL_WORDS
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        user_osc_en,
    input  wire logic        check_start,
    input  wire logic [15:0] cell_data,
    output logic      [7:0]  cell_addr,
    output logic             osc_run,
    output logic             tree_clk_en,
    output logic             pll_ref_en,
    output logic             mclk_en,
    output logic             user_div_en,
    output logic             check_clk_en,
    output logic             check_done,
    output logic             check_err,
    output logic             irq
);
    localparam int AW = 8;
    initial begin
        if (WORDS < 1 || WORDS > 256) $error("osc_clock_ctrl: WORDS out of range");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [4:0]        mclk_sel;
        logic              mclk_chosen;
        logic              mclk_restart;
        logic [15:0]       udiv;
        logic [15:0]       sdiv;
        logic [15:0]       expect_crc;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_en;
        logic [31:0]       rdata;
        logic              osc_run;
        logic              tree_en;
        logic              pll_en;
        logic              start;
        logic              start_prev;
        logic              auto_fired;
        logic              done;
        logic              err;
        logic              irq;
    } top_state_type;
    top_state_type st, next_st;

    check_if #(.AW(AW)) chk ();
    logic            mclk_tick;
    logic            udiv_tick;
    logic            sdiv_tick;
    logic            wr_ctrl;
    logic            wr_mclk;
    logic            start_req;
    logic            pass;
    logic [IRQ_W-1:0] events;

    // ---------------------------------------------------------------
    // dividers
    // ---------------------------------------------------------------
    rate_divider #(.W(DIV_W)) mclk_div (
        .clk     (clk),
        .rstn    (rstn),
        .run     (st.osc_run),
        .restart (st.mclk_restart),
        .step    (MCLK_RATE[st.mclk_sel]),
        .modulus (CLK_RATE),
        .tick    (mclk_tick)
    );
    rate_divider #(.W(DIV_W)) user_div (
        .clk     (clk),
        .rstn    (rstn),
        .run     (st.osc_run),
        .restart (1'b0),
        .step    (16'h0001),
        .modulus ((st.udiv == 16'h0000) ? 16'h0001 : st.udiv),
        .tick    (udiv_tick)
    );
    // fed by the raw oscillator, never by the master clock divider
    rate_divider #(.W(DIV_W)) check_div (
        .clk     (clk),
        .rstn    (rstn),
        .run     (st.osc_run && st.ctrl[CTRL_CHK_PWR]),
        .restart (1'b0),
        .step    (16'h0001),
        .modulus ((st.sdiv == 16'h0000) ? 16'h0001 : st.sdiv),
        .tick    (sdiv_tick)
    );

    crc_engine #(.WORDS(WORDS), .AW(AW)) engine (
        .clk  (clk),
        .rstn (rstn),
        .chk  (chk.engine)
    );
    assign chk.start = st.start;
    assign chk.power = st.ctrl[CTRL_CHK_PWR];
    assign chk.tick  = sdiv_tick;
    assign chk.data  = cell_data;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    assign wr_ctrl   = wr && (addr == CTRL_ADDR);
    assign wr_mclk   = wr && (addr == MCLK_ADDR) && (wdata[4:0] < 5'(RATE_COUNT));
    assign pass      = (chk.crc == st.expect_crc);
    assign events    = {st.mclk_restart, chk.done && !pass, chk.done && pass};

    always_comb begin
        next_st = st;
        next_st.mclk_restart = 1'b0;
        next_st.start        = 1'b0;
        next_st.rdata        = 32'h0000_0000;
        next_st.start_prev   = check_start;
        start_req            = 1'b0;

        if (wr_ctrl) begin
            // configuration-complete bit is sticky once set
            next_st.ctrl = wdata[CTRL_W-1:0] | (st.ctrl & (CTRL_W'(1) << CTRL_CFG_OK));
        end
        if (wr_mclk) begin
            next_st.mclk_sel     = wdata[4:0];
            next_st.mclk_chosen  = 1'b1;
            next_st.mclk_restart = 1'b1;
        end
        if (wr && (addr == UDIV_ADDR)) next_st.udiv = wdata[15:0];
        if (wr && (addr == SDIV_ADDR)) next_st.sdiv = wdata[15:0];
        if (wr && (addr == EXPECT_ADDR)) next_st.expect_crc = wdata[15:0];
        if (wr && (addr == IRQ_EN_ADDR)) next_st.irq_en = wdata[IRQ_W-1:0];

        // gate both enables; either one stops the oscillator
        next_st.osc_run = next_st.ctrl[CTRL_OSC_EN] && user_osc_en;
        next_st.tree_en = next_st.osc_run && next_st.ctrl[CTRL_TREE_EN];
        next_st.pll_en  = next_st.osc_run && next_st.ctrl[CTRL_PLL_EN];

        // one automatic check when configuration completes
        if (st.ctrl[CTRL_CFG_OK] && st.ctrl[CTRL_CHK_EN] && !st.auto_fired) begin
            next_st.auto_fired = 1'b1;
            start_req          = 1'b1;
        end
        if (check_start && !st.start_prev) start_req = 1'b1;
        if (start_req && st.ctrl[CTRL_CHK_PWR] && !chk.busy && !st.start) begin
            next_st.start = 1'b1;
            next_st.done  = 1'b0;
            next_st.err   = 1'b0;
        end
        if (chk.done) begin
            next_st.done = pass;
            next_st.err  = !pass;
        end

        // set wins over a clear arriving in the same cycle
        if (wr && (addr == IRQ_CLR_ADDR)) begin
            next_st.irq_stat = st.irq_stat & ~wdata[IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | events;
        next_st.irq      = |(next_st.irq_stat & next_st.irq_en);

        if (rd) begin
            unique case (addr)
                CTRL_ADDR:     next_st.rdata = 32'(st.ctrl);
                MCLK_ADDR:     next_st.rdata = {26'h0, st.mclk_chosen, st.mclk_sel};
                UDIV_ADDR:     next_st.rdata = {16'h0000, st.udiv};
                SDIV_ADDR:     next_st.rdata = {16'h0000, st.sdiv};
                EXPECT_ADDR:   next_st.rdata = {16'h0000, st.expect_crc};
                STATUS_ADDR:   next_st.rdata = {chk.crc, 11'h000, st.err, st.done,
                                                chk.busy, st.ctrl[CTRL_CFG_OK], st.osc_run};
                IRQ_STAT_ADDR: next_st.rdata = 32'(st.irq_stat);
                IRQ_EN_ADDR:   next_st.rdata = 32'(st.irq_en);
                default:       next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st            <= '0;
            st.ctrl       <= CTRL_RESET;
            st.mclk_sel   <= MCLK_DEFAULT;
            st.udiv       <= UDIV_RESET;
            st.sdiv       <= SDIV_RESET;
            st.expect_crc <= EXPECT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata        = st.rdata;
    assign cell_addr    = chk.addr;
    assign osc_run      = st.osc_run;
    assign tree_clk_en  = st.tree_en;
    assign pll_ref_en   = st.pll_en;
    assign mclk_en      = mclk_tick;
    assign user_div_en  = udiv_tick;
    assign check_clk_en = sdiv_tick;
    assign check_done   = st.done;
    assign check_err    = st.err;
    assign irq          = st.irq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_osc_gate_off: assert property (@(posedge clk) disable iff (!rstn)
        (!user_osc_en || !next_st.ctrl[CTRL_OSC_EN]) |=> !osc_run ##1
            (!mclk_en && !user_div_en && !check_clk_en))
        else $error("oscillator ran without both enables");
    chk_route_follow: assert property (@(posedge clk) disable iff (!rstn)
        (tree_clk_en |-> osc_run && st.ctrl[CTRL_TREE_EN]) and
        (pll_ref_en |-> osc_run && st.ctrl[CTRL_PLL_EN]))
        else $error("clock routed while oscillator stopped");
    chk_user_div_gap: assert property (@(posedge clk) disable iff (!rstn)
        (user_div_en && st.udiv > 16'h0001 && $stable(st.udiv)) |=> !user_div_en)
        else $error("divided clock ticked on back to back cycles");
    chk_mclk_default: assert property (@(posedge clk) disable iff (!rstn)
        !st.mclk_chosen |-> st.mclk_sel == MCLK_DEFAULT)
        else $error("master clock left its default without a selection");
    chk_mclk_switch: assert property (@(posedge clk) disable iff (!rstn)
        wr_mclk |=> st.mclk_sel == $past(wdata[4:0]) && st.mclk_restart ##1 !mclk_en)
        else $error("master clock did not switch on selection");
    chk_mclk_range: assert property (@(posedge clk) disable iff (!rstn)
        st.mclk_sel < 5'(RATE_COUNT) && MCLK_RATE[st.mclk_sel] >= 16'h00D0 &&
        MCLK_RATE[st.mclk_sel] <= 16'h33F4)
        else $error("master clock rate outside the table");
    chk_auto_check: assert property (@(posedge clk) disable iff (!rstn)
        ($rose(st.ctrl[CTRL_CFG_OK]) && st.ctrl[CTRL_CHK_EN] && st.ctrl[CTRL_CHK_PWR]
            && !chk.busy && !st.start) |-> ##[1:2] chk.busy)
        else $error("no check after configuration completed");
    chk_user_start: assert property (@(posedge clk) disable iff (!rstn)
        ($rose(check_start) && st.ctrl[CTRL_CHK_PWR] && $stable(st.ctrl)
            && !chk.busy && !st.start) |-> ##[1:3] chk.busy)
        else $error("fabric start did not launch a check");
    chk_check_hold: assert property (@(posedge clk) disable iff (!rstn)
        (chk.busy && !check_clk_en && chk.power) |=> $stable(chk.addr) && $stable(chk.crc))
        else $error("check advanced without its clock");
    chk_power_off: assert property (@(posedge clk) disable iff (!rstn)
        !st.ctrl[CTRL_CHK_PWR] |=> !chk.busy && !check_clk_en)
        else $error("check circuit active while switched off");
    chk_result_flag: assert property (@(posedge clk) disable iff (!rstn)
        chk.done |=> (check_err == ($past(chk.crc) != st.expect_crc)) &&
            (check_done != check_err))
        else $error("check result flags disagree with crc");
endmodule : osc_clock_ctrl
`default_nettype wire

//--- rtl/osc_pkg.sv
// constants shared by the oscillator, master clock and soft-error-check logic
// assumes one 100 MHz clock standing for the undivided oscillator output
`default_nettype none
package osc_pkg;
    // ---------------------------------------------------------------
    // clock figures, in 10 kHz units
    // ---------------------------------------------------------------
    localparam int       CLK_MHZ        = 100;
    localparam int       RATE_UNIT_KHZ  = 10;
    localparam int       DIV_W          = 16;
    localparam logic [15:0] CLK_RATE    = 16'(CLK_MHZ * 1000 / RATE_UNIT_KHZ);
    localparam int       RATE_COUNT     = 21;
    localparam logic [4:0]  MCLK_DEFAULT = 5'h00;
    localparam logic [15:0] MCLK_RATE [RATE_COUNT] = '{
        16'h00D0, 16'h00F6, 16'h013D, 16'h01AD, 16'h022A, 16'h02BC, 16'h033F,
        16'h0395, 16'h03FF, 16'h0532, 16'h05C6, 16'h07FE, 16'h0A64, 16'h0B8C,
        16'h0CFD, 16'h0ED8, 16'h1151, 16'h14C8, 16'h19FA, 16'h22A3, 16'h33F4};
    // ---------------------------------------------------------------
    // register map, byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR     = 8'h00;
    localparam logic [7:0] MCLK_ADDR     = 8'h04;
    localparam logic [7:0] UDIV_ADDR     = 8'h08;
    localparam logic [7:0] SDIV_ADDR     = 8'h0C;
    localparam logic [7:0] EXPECT_ADDR   = 8'h10;
    localparam logic [7:0] STATUS_ADDR   = 8'h14;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h18;
    localparam logic [7:0] IRQ_CLR_ADDR  = 8'h1C;
    localparam logic [7:0] IRQ_EN_ADDR   = 8'h20;
    // control bits
    localparam int CTRL_OSC_EN  = 0;
    localparam int CTRL_CHK_EN  = 1;
    localparam int CTRL_CHK_PWR = 2;
    localparam int CTRL_PLL_EN  = 3;
    localparam int CTRL_TREE_EN = 4;
    localparam int CTRL_CFG_OK  = 5;
    localparam int CTRL_W       = 6;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_MCLK = 2;
    localparam int IRQ_W    = 3;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 6'h15;
    localparam logic [15:0]       UDIV_RESET   = 16'h0002;
    localparam logic [15:0]       SDIV_RESET   = 16'h0008;
    localparam logic [15:0]       EXPECT_RESET = 16'h0000;
    // check engine
    localparam int          CELL_WORDS = 16;
    localparam logic [15:0] CRC_INIT   = 16'hFFFF;
    localparam logic [15:0] CRC_POLY   = 16'h1021;
endpackage : osc_pkg
`default_nettype wire

//--- rtl/check_if.sv
// bundle between the check controller and the crc engine
// assumes both ends share one clock
`default_nettype none
interface check_if #(parameter int AW = 4);
    logic          start;
    logic          power;
    logic          tick;
    logic [15:0]   data;
    logic [AW-1:0] addr;
    logic          busy;
    logic          done;
    logic [15:0]   crc;
    modport ctrl   (output start, power, tick, data, input addr, busy, done, crc);
    modport engine (input start, power, tick, data, output addr, busy, done, crc);
endinterface : check_if
`default_nettype wire

//--- rtl/rate_divider.sv
// fractional rate divider: one-cycle tick at step/modulus of the clock rate
// assumes modulus is nonzero; step at or above modulus ticks every cycle
`default_nettype none
module rate_divider
    import osc_pkg::*;
#(
    parameter int W = DIV_W
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         run,
    input  wire logic         restart,
    input  wire logic [W-1:0] step,
    input  wire logic [W-1:0] modulus,
    output logic              tick
);
    initial begin
        if (W < 2) $error("rate_divider needs W of at least 2");
    end
    typedef struct packed {
        logic [W-1:0] acc;
        logic         tick;
    } div_state_type;
    div_state_type st, next_st;
    logic [W:0]    sum;

    always_comb begin
        next_st = st;
        sum = {1'b0, st.acc} + {1'b0, step};
        next_st.tick = 1'b0;
        if (!run || restart) begin
            next_st.acc = '0;
        end else if (step >= modulus) begin
            next_st.acc  = '0;
            next_st.tick = 1'b1;
        end else if (sum >= {1'b0, modulus}) begin
            next_st.acc  = W'(sum - {1'b0, modulus});
            next_st.tick = 1'b1;
        end else begin
            next_st.acc = sum[W-1:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) st <= '0;
        else st <= next_st;
    end
    assign tick = st.tick;
endmodule : rate_divider
`default_nettype wire

//--- rtl/crc_engine.sv
// crc walk over the configuration cells, one word per check-clock tick
// assumes the cell array answers the address within the same cycle
`default_nettype none
module crc_engine
    import osc_pkg::*;
#(
    parameter int WORDS = CELL_WORDS,
    parameter int AW    = 4
) (
    input  wire logic clk,
    input  wire logic rstn,
    check_if.engine   chk
);
    initial begin
        if (WORDS < 1 || WORDS > (1 << AW)) $error("crc_engine: WORDS does not fit AW");
    end
    typedef enum logic {IDLE, RUN} phase_type;
    typedef struct packed {
        phase_type     phase;
        logic [AW-1:0] addr;
        logic [15:0]   crc;
        logic          done;
    } eng_state_type;
    eng_state_type st, next_st;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (!chk.power) begin
            // powered off: nothing toggles
            next_st = '0;
        end else begin
            unique case (st.phase)
                IDLE: begin
                    if (chk.start) begin
                        next_st.phase = RUN;
                        next_st.addr  = '0;
                        next_st.crc   = CRC_INIT;
                    end
                end
                RUN: begin
                    if (chk.tick) begin
                        next_st.crc = crc_step(st.crc, chk.data);
                        if (st.addr == AW'(WORDS - 1)) begin
                            next_st.phase = IDLE;
                            next_st.done  = 1'b1;
                        end else begin
                            next_st.addr = st.addr + 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) st <= '0;
        else st <= next_st;
    end
    assign chk.addr = st.addr;
    assign chk.busy = (st.phase == RUN);
    assign chk.done = st.done;
    assign chk.crc  = st.crc;
endmodule : crc_engine
`default_nettype wire

//--- sim/fabric_model.sv
// user fabric stand-in: oscillator enable, check start and the cell array
// assumes it shares clk with the block and is steered by tasks called from tb
`default_nettype none
module fabric_model #(
    parameter int WORDS = 4
) (
    input  wire logic        clk,
    input  wire logic [7:0]  cell_addr,
    output logic      [15:0] cell_data,
    output logic             user_osc_en,
    output logic             check_start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [WORDS];
    initial begin
        user_osc_en = 1'b0;
        check_start = 1'b0;
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = 16'(16'h1357 + i * 16'h2461);
        end
    end
    // beyond the array the word follows the address, so a stale value never matches
    assign cell_data = (int'(cell_addr) < WORDS) ? mem[cell_addr[1:0]] : {cell_addr, ~cell_addr};
    task automatic set_osc(input logic v);
        @(posedge clk);
        user_osc_en <= v;
    endtask : set_osc
    task automatic pulse_start();
        @(posedge clk);
        check_start <= 1'b1;
        @(posedge clk);
        check_start <= 1'b0;
    endtask : pulse_start
endmodule : fabric_model
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the oscillator, master clock and check controller
// assumes the design package osc_pkg and a fabric model on the far side
`default_nettype none
module tb
    import osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 4;
    logic clk, rstn, wr, rd, user_osc_en, check_start, osc_run, tree_clk_en, pll_ref_en;
    logic mclk_en, user_div_en, check_clk_en, check_done, check_err, irq;
    logic [7:0]  addr, cell_addr;
    logic [31:0] wdata, rdata;
    logic [15:0] cell_data, g;
    int fails, n_checks, c, e;
    typedef struct packed {
        logic [7:0]  a;
        logic        wr_it;
        logic [31:0] w;
        logic [31:0] exp;
    } row_type;
    row_type rows [8] = '{
        '{CTRL_ADDR, 1'b0, 32'h0, 32'h15}, '{MCLK_ADDR, 1'b0, 32'h0, 32'h0},
        '{UDIV_ADDR, 1'b0, 32'h0, 32'h2}, '{SDIV_ADDR, 1'b0, 32'h0, 32'h8},
        '{EXPECT_ADDR, 1'b0, 32'h0, 32'h0}, '{IRQ_EN_ADDR, 1'b0, 32'h0, 32'h0},
        '{8'h24, 1'b1, 32'hFFFF_FFFF, 32'h0}, '{UDIV_ADDR, 1'b1, 32'h0001_0005, 32'h5}};
    osc_clock_ctrl #(.WORDS(WORDS)) u_osc_clock_ctrl (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .user_osc_en(user_osc_en),
        .check_start(check_start), .cell_data(cell_data), .cell_addr(cell_addr),
        .osc_run(osc_run), .tree_clk_en(tree_clk_en), .pll_ref_en(pll_ref_en),
        .mclk_en(mclk_en), .user_div_en(user_div_en), .check_clk_en(check_clk_en),
        .check_done(check_done), .check_err(check_err), .irq(irq));
    fabric_model #(.WORDS(WORDS)) u_fabric_model (.clk(clk), .cell_addr(cell_addr),
        .cell_data(cell_data), .user_osc_en(user_osc_en), .check_start(check_start));
    always #5 clk = ~clk;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic wrap_up();
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chkr(input int got, input int lo, input int hi, input string m);
        n_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD %0t %s got %0d want %0d..%0d", $time, m, got, lo, hi);
        end
    endtask : chkr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp, "register read");
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic count(input int sel, input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            k += int'(sel == 0 ? mclk_en === 1'b1 : sel == 1 ? user_div_en === 1'b1
                      : check_clk_en === 1'b1);
        end
    endtask : count
    task automatic wait_for(input logic want_err);
        int k;
        k = 0;
        while (((want_err ? check_err : check_done) !== 1'b1) && k < 2000) begin
            settle(1);
            k++;
        end
        if (k >= 2000) begin
            fails++;
            $display("BAD %0t check never finished", $time);
            wrap_up();
        end
    endtask : wait_for
    function automatic logic [15:0] golden();
        logic [15:0] r;
        r = CRC_INIT;
        for (int w = 0; w < WORDS; w++) begin
            for (int b = 15; b >= 0; b--) begin
                r = {r[14:0], 1'b0} ^ ((r[15] ^ u_fabric_model.mem[w][b]) ? CRC_POLY : 16'h0000);
            end
        end
        return r;
    endfunction : golden
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0; rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        fails = 0; n_checks = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr_it) wr_reg(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].exp);
        end
        chk(osc_run, 1'b0, "osc ran without user enable");
        u_fabric_model.set_osc(1'b1);
        settle(3);
        chk({osc_run, tree_clk_en, pll_ref_en}, 3'b110, "osc routing");
        wr_reg(CTRL_ADDR, 32'h14);
        settle(2);
        chk(osc_run, 1'b0, "osc ran with config enable off");
        wr_reg(CTRL_ADDR, 32'h0D);
        settle(2);
        chk({osc_run, tree_clk_en, pll_ref_en}, 3'b101, "pll route");
        wr_reg(CTRL_ADDR, 32'h15);
        count(1, 50, c);
        chkr(c, 10, 10, "user divider");
        for (int i = 0; i < RATE_COUNT; i++) begin
            if (i > 0) wr_reg(MCLK_ADDR, 32'(i));
            settle(4);
            count(0, 1000, c);
            e = 1000 * int'(MCLK_RATE[i]) / int'(CLK_RATE);
            if (e > 1000) e = 1000;
            chkr(c, e - 1, e + 1, "master clock rate");
        end
        rd_chk(MCLK_ADDR, 32'h34);
        wr_reg(MCLK_ADDR, 32'd21);
        rd_chk(MCLK_ADDR, 32'h34);
        rd_chk(IRQ_STAT_ADDR, 32'h4);
        wr_reg(SDIV_ADDR, 32'h3);
        settle(4);
        count(2, 30, c);
        chkr(c, 10, 10, "check divider");
        g = golden();
        wr_reg(EXPECT_ADDR, {16'h0, g});
        wr_reg(IRQ_CLR_ADDR, 32'h7);
        u_fabric_model.pulse_start();
        wait_for(1'b0);
        chk({check_err, irq}, 2'b00, "good check or masked irq");
        rd_chk(STATUS_ADDR, {g, 16'h0009});
        rd_chk(IRQ_STAT_ADDR, 32'h1);
        wr_reg(IRQ_EN_ADDR, 32'h1);
        settle(2);
        chk(irq, 1'b1, "enabled irq");
        wr_reg(IRQ_CLR_ADDR, 32'h1);
        settle(2);
        chk(irq, 1'b0, "cleared irq");
        wr_reg(EXPECT_ADDR, {16'h0, g ^ 16'h0001});
        wr_reg(IRQ_EN_ADDR, 32'h2);
        u_fabric_model.pulse_start();
        wait_for(1'b1);
        settle(2);
        chk({check_done, irq}, 2'b01, "mismatch flagged");
        wr_reg(IRQ_CLR_ADDR, 32'h2);
        wr_reg(EXPECT_ADDR, {16'h0, g});
        wr_reg(CTRL_ADDR, 32'h37);
        wait_for(1'b0);
        chk(check_err, 1'b0, "check after configuration");
        // power drops after at most two of the four words, so the check cannot finish
        u_fabric_model.pulse_start();
        settle(5);
        wr_reg(CTRL_ADDR, 32'h33);
        settle(100);
        chk({check_done, check_err}, 2'b00, "aborted check finished");
        count(2, 40, c);
        chkr(c, 0, 0, "check clock while off");
        u_fabric_model.pulse_start();
        settle(100);
        chk({check_done, check_err}, 2'b00, "check ran while off");
        // mid-run reset: defaults return, oscillator resumes one cycle after release
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        settle(2);
        chk({osc_run, check_done, check_err, irq}, 4'b1000, "state after reset");
        rd_chk(MCLK_ADDR, 32'h0);
        rd_chk(CTRL_ADDR, 32'h15);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
